// ### core/eswc_device.sv
// Contract
// - Enable high keeps every function running.
// - Enable low forces all gates low.
// - Low-power entry only after 1 ms low.
// - Standby drops amplifiers and 12V regulator.
// - Translator variant drops 5V when disabled.
// - Enable rise clears fault if gone.
// - Sleep bit chooses Sleep over Standby.
// - Host toggles enable under 1 ms.
// - Enable low 250 us, wake on rise.
// - Translators pass input to open-drain output.
// - Pull-up select sampled only while disabled.
// - Wake on input rise after 250 us low.
// - Bus pull-up setting changes only in Standby.
// - Bus pull-up on when active, off asleep.
// - Wake on bus rise after 150 us dominant.
// - Master holds bus dominant over 250 us.
// - Bus driven only by transmit data, low only.
// - Dead time from host or config register.
// - Six commands drive six gates, active high.
// - Current-fault output low on overcurrent or fault.
// - Receive output follows bus level.
// - Transmit low dominant, high recessive.
`include "eswc_defines.svh"

module eswc_device #(
   parameter eswc_pkg::eswc_variant_t VARIANT = eswc_pkg::ESWC_VAR_LIN,
   parameter int CE_QUAL_CYC = `ESWC_CE_QUAL_CYC,
   parameter int WAKE_LOW_CYC = `ESWC_WAKE_LOW_CYC,
   parameter int LIN_DOM_CYC = `ESWC_LIN_DOM_CYC,
   parameter int DT_WIDTH = `ESWC_DT_WIDTH
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Link to host
   eswc_if.device link,
   // Configuration
   input wire logic config_sleep_bit,
   input wire logic pullup_select_bit,
   input wire logic [DT_WIDTH-1:0] config_reg_two,
   // Analog side
   input wire logic fault_condition,
   input wire logic overcurrent,
   input wire logic high_volt_input_one,
   input wire logic high_volt_input_two,
   input wire logic lin_bus_i,
   output logic lin_bus_o,
   output logic lin_bus_oe,
   output logic lin_pullup_en,
   output logic xlate_pullup_en,
   output logic amp_en,
   output logic reg12_en,
   output logic reg5_en,
   output logic buck_en,
   output logic supervisor_en,
   output eswc_pkg::eswc_mode_t power_mode,
   output logic fault_latched,
   // Gate outputs
   output logic phase_a_high_gate,
   output logic phase_b_high_gate,
   output logic phase_c_high_gate,
   output logic phase_a_low_gate,
   output logic phase_b_low_gate,
   output logic phase_c_low_gate
);
   import eswc_pkg::*;

   localparam int CW = 16;

   eswc_mode_t mode_reg;
   logic ce_d_reg;
   logic [CW-1:0] ce_low_cnt_reg;
   logic [CW-1:0] hv1_low_cnt_reg;
   logic [CW-1:0] lin_dom_cnt_reg;
   logic hv1_d_reg;
   logic lin_d_reg;
   logic fault_reg;
   logic xpu_reg;
   logic lpu_reg;
   logic [2:0] hi_q_reg;
   logic [2:0] lo_q_reg;
   logic [DT_WIDTH-1:0] dt_cnt_reg [0:5];
   logic ce_rise;
   logic ce_qual;
   logic wake;
   logic [2:0] gate_hi;
   logic [2:0] gate_lo;

   assign ce_rise = link.chip_enable & ~ce_d_reg;
   assign ce_qual = ce_low_cnt_reg >= CW'(CE_QUAL_CYC - 1);

   // ==========================================
   // Edge history and low-time counters
   always_ff @(posedge mclk) begin
      if (reset) begin
         ce_d_reg <= 1'b0;
         hv1_d_reg <= 1'b1;
         lin_d_reg <= 1'b1;
      end else begin
         ce_d_reg <= link.chip_enable;
         hv1_d_reg <= high_volt_input_one;
         lin_d_reg <= lin_bus_i;
      end
   end

   // Saturating, so long lows never wrap back under the threshold
   always_ff @(posedge mclk) begin
      if (reset || link.chip_enable) begin
         ce_low_cnt_reg <= '0;
      end else if (ce_low_cnt_reg != {CW{1'b1}}) begin
         ce_low_cnt_reg <= ce_low_cnt_reg + CW'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset || high_volt_input_one) begin
         hv1_low_cnt_reg <= '0;
      end else if (hv1_low_cnt_reg != {CW{1'b1}}) begin
         hv1_low_cnt_reg <= hv1_low_cnt_reg + CW'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset || lin_bus_i) begin
         lin_dom_cnt_reg <= '0;
      end else if (lin_dom_cnt_reg != {CW{1'b1}}) begin
         lin_dom_cnt_reg <= lin_dom_cnt_reg + CW'(1);
      end
   end

   // ==========================================
   // Power mode
   always_comb begin
      wake = 1'b0;
      if (ce_rise && ce_d_reg == 1'b0 && ce_low_cnt_reg >= CW'(WAKE_LOW_CYC)) begin
         wake = 1'b1;
      end
      if (VARIANT == ESWC_VAR_XLATE && high_volt_input_one && !hv1_d_reg
          && hv1_low_cnt_reg > CW'(WAKE_LOW_CYC)) begin
         wake = 1'b1;
      end
      if (VARIANT == ESWC_VAR_LIN && lin_bus_i && !lin_d_reg
          && lin_dom_cnt_reg > CW'(LIN_DOM_CYC)) begin
         wake = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         mode_reg <= ESWC_ACTIVE;
      end else begin
         case (mode_reg)
            ESWC_ACTIVE: begin
               if (!link.chip_enable && ce_qual) begin
                  mode_reg <= config_sleep_bit ? ESWC_SLEEP : ESWC_STANDBY;
               end
            end
            ESWC_STANDBY: begin
               if (link.chip_enable) begin
                  mode_reg <= ESWC_ACTIVE;
               end
            end
            ESWC_SLEEP: begin
               if (wake) begin
                  mode_reg <= ESWC_ACTIVE;
               end
            end
            default: mode_reg <= ESWC_ACTIVE;
         endcase
      end
   end
   assign power_mode = mode_reg;

   // Supply enables
   assign amp_en = link.chip_enable && mode_reg == ESWC_ACTIVE;
   assign reg12_en = mode_reg == ESWC_ACTIVE;
   assign reg5_en = (VARIANT == ESWC_VAR_XLATE) ? link.chip_enable : mode_reg != ESWC_SLEEP;
   assign buck_en = mode_reg != ESWC_SLEEP;
   assign supervisor_en = mode_reg != ESWC_SLEEP;

   // ==========================================
   // Fault latch; a new fault wins over a clearing edge
   always_ff @(posedge mclk) begin
      if (reset) begin
         fault_reg <= 1'b0;
      end else if (fault_condition) begin
         fault_reg <= 1'b1;
      end else if (ce_rise) begin
         fault_reg <= 1'b0;
      end
   end
   assign fault_latched = fault_reg;

   // ==========================================
   // Pull-up selection
   always_ff @(posedge mclk) begin
      if (reset) begin
         xpu_reg <= 1'b0;
         lpu_reg <= 1'b1;
      end else begin
         if (!link.chip_enable) begin
            xpu_reg <= pullup_select_bit;
         end
         if (mode_reg == ESWC_STANDBY) begin
            lpu_reg <= pullup_select_bit;
         end
      end
   end
   assign xlate_pullup_en = xpu_reg;
   assign lin_pullup_en = (mode_reg == ESWC_ACTIVE) ? 1'b1 : (mode_reg == ESWC_SLEEP) ? 1'b0 : lpu_reg;

   // ==========================================
   // Gate drive with optional dead-time insertion
   // Zero delay setting still delays each rising edge by one clock; falling edges pass untouched
   always_ff @(posedge mclk) begin
      if (reset) begin
         hi_q_reg <= '0;
         lo_q_reg <= '0;
      end else begin
         hi_q_reg <= link.phase_high_cmd;
         lo_q_reg <= link.phase_low_cmd;
      end
   end

   generate
      for (genvar i = 0; i < 3; i++) begin : g_phase
         always_ff @(posedge mclk) begin
            if (reset || !link.phase_high_cmd[i] || link.phase_high_cmd[i] != hi_q_reg[i]) begin
               dt_cnt_reg[i] <= '0;
            end else if (dt_cnt_reg[i] < config_reg_two) begin
               dt_cnt_reg[i] <= dt_cnt_reg[i] + DT_WIDTH'(1);
            end
         end
         always_ff @(posedge mclk) begin
            if (reset || !link.phase_low_cmd[i] || link.phase_low_cmd[i] != lo_q_reg[i]) begin
               dt_cnt_reg[i+3] <= '0;
            end else if (dt_cnt_reg[i+3] < config_reg_two) begin
               dt_cnt_reg[i+3] <= dt_cnt_reg[i+3] + DT_WIDTH'(1);
            end
         end
         // Gates drop combinationally on enable low; a clocked path would miss 100 ns
         assign gate_hi[i] = link.chip_enable && link.phase_high_cmd[i] && mode_reg == ESWC_ACTIVE
                             && hi_q_reg[i] && dt_cnt_reg[i] >= config_reg_two;
         assign gate_lo[i] = link.chip_enable && link.phase_low_cmd[i] && mode_reg == ESWC_ACTIVE
                             && lo_q_reg[i] && dt_cnt_reg[i+3] >= config_reg_two;
      end
   endgenerate

   assign phase_a_high_gate = gate_hi[0];
   assign phase_b_high_gate = gate_hi[1];
   assign phase_c_high_gate = gate_hi[2];
   assign phase_a_low_gate = gate_lo[0];
   assign phase_b_low_gate = gate_lo[1];
   assign phase_c_low_gate = gate_lo[2];

   // ==========================================
   // Open-drain pins
   assign lin_bus_o = 1'b0;
   assign lin_bus_oe = !link.lin_tx_data && mode_reg != ESWC_SLEEP;
   assign link.lin_rx_data_o = 1'b0;
   assign link.lin_rx_data_oe = !lin_bus_i;
   assign link.current_fault_output_o = 1'b0;
   assign link.current_fault_output_oe = overcurrent | fault_reg;
   assign link.low_volt_output_one_o = 1'b0;
   assign link.low_volt_output_one_oe = !high_volt_input_one;
   assign link.low_volt_output_two_o = 1'b0;
   assign link.low_volt_output_two_oe = !high_volt_input_two;
endmodule

// ### core/eswc_defines.svh
`ifndef ESWC_DEFINES_SVH
`define ESWC_DEFINES_SVH

// ==========================================
// Clock and timing
`define ESWC_CLK_HZ 25000000
`define ESWC_CE_QUAL_US 1000
`define ESWC_CE_QUAL_CYC ((`ESWC_CE_QUAL_US * (`ESWC_CLK_HZ / 1000000)))
`define ESWC_WAKE_LOW_US 250
`define ESWC_WAKE_LOW_CYC ((`ESWC_WAKE_LOW_US * (`ESWC_CLK_HZ / 1000000)))
`define ESWC_LIN_DOM_US 150
`define ESWC_LIN_DOM_CYC ((`ESWC_LIN_DOM_US * (`ESWC_CLK_HZ / 1000000)))
`define ESWC_HOST_DOM_US 260
`define ESWC_HOST_DOM_CYC ((`ESWC_HOST_DOM_US * (`ESWC_CLK_HZ / 1000000)))
`define ESWC_HOST_TOGGLE_CYC 32

// ==========================================
// Configuration field positions and reset values
`define ESWC_CONFIG_REG_ZERO_SLEEP_BIT 0
`define ESWC_CONFIG_REG_ZERO_PULLUP_BIT 1
`define ESWC_CONFIG_REG_ZERO_RESET 2'h0
`define ESWC_DT_WIDTH 4
`define ESWC_DT_RESET 4'h0

`endif

// ### core/eswc_pkg.sv
package eswc_pkg;
   typedef enum logic [1:0] {
      ESWC_ACTIVE  = 2'b00,
      ESWC_STANDBY = 2'b01,
      ESWC_SLEEP   = 2'b10
   } eswc_mode_t;

   typedef enum logic [0:0] {
      ESWC_VAR_LIN   = 1'b0,
      ESWC_VAR_XLATE = 1'b1
   } eswc_variant_t;
endpackage

// ### core/eswc_if.sv
interface eswc_if;
   // Host to device
   logic chip_enable;
   logic [2:0] phase_high_cmd;
   logic [2:0] phase_low_cmd;
   logic lin_tx_data;
   // Device to host
   logic lin_rx_data_o;
   logic lin_rx_data_oe;
   logic current_fault_output_o;
   logic current_fault_output_oe;
   logic low_volt_output_one_o;
   logic low_volt_output_one_oe;
   logic low_volt_output_two_o;
   logic low_volt_output_two_oe;
   // Resolved open-drain levels with external pull-ups
   logic lin_rx_data;
   logic current_fault_output;
   logic low_volt_output_one;
   logic low_volt_output_two;
   assign lin_rx_data = ~(lin_rx_data_oe & ~lin_rx_data_o);
   assign current_fault_output = ~(current_fault_output_oe & ~current_fault_output_o);
   assign low_volt_output_one = ~(low_volt_output_one_oe & ~low_volt_output_one_o);
   assign low_volt_output_two = ~(low_volt_output_two_oe & ~low_volt_output_two_o);

   modport device (
      input chip_enable, phase_high_cmd, phase_low_cmd, lin_tx_data,
      output lin_rx_data_o, lin_rx_data_oe, current_fault_output_o, current_fault_output_oe,
      output low_volt_output_one_o, low_volt_output_one_oe, low_volt_output_two_o, low_volt_output_two_oe
   );
   modport host (
      output chip_enable, phase_high_cmd, phase_low_cmd, lin_tx_data,
      input lin_rx_data, current_fault_output, low_volt_output_one, low_volt_output_two
   );
endinterface

// ### core/eswc_host.sv
`include "eswc_defines.svh"

module eswc_host #(
   parameter int TOGGLE_CYC = `ESWC_HOST_TOGGLE_CYC,
   parameter int WAKE_LOW_CYC = `ESWC_WAKE_LOW_CYC,
   parameter int DOM_CYC = `ESWC_HOST_DOM_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Link to device
   eswc_if.host link,
   // User requests
   input wire logic user_enable,
   input wire logic fault_clear_req,
   input wire logic wake_req,
   input wire logic [2:0] user_high_cmd,
   input wire logic [2:0] user_low_cmd,
   input wire logic user_tx_data,
   input wire logic bus_wake_req,
   output logic busy,
   output logic bus_wake_drive,
   // Observed device pins
   output logic rx_data,
   output logic fault_seen
);
   import eswc_pkg::*;

   localparam int CW = 16;

   logic [CW-1:0] low_cnt_reg;
   logic [CW-1:0] dom_cnt_reg;
   logic ce_reg;
   logic dom_reg;

   assign busy = low_cnt_reg != '0;

   // ==========================================
   // Enable pulse generator; clear pulse stays well under 1 ms
   always_ff @(posedge mclk) begin
      if (reset) begin
         low_cnt_reg <= '0;
         ce_reg <= 1'b0;
      end else if (busy) begin
         low_cnt_reg <= low_cnt_reg - CW'(1);
         ce_reg <= (low_cnt_reg == CW'(1)) && user_enable;
      end else if (fault_clear_req) begin
         low_cnt_reg <= CW'(TOGGLE_CYC);
         ce_reg <= 1'b0;
      end else if (wake_req) begin
         low_cnt_reg <= CW'(WAKE_LOW_CYC + 1);
         ce_reg <= 1'b0;
      end else begin
         ce_reg <= user_enable;
      end
   end

   // Bus wake: dominant hold beyond minimum
   always_ff @(posedge mclk) begin
      if (reset) begin
         dom_cnt_reg <= '0;
         dom_reg <= 1'b0;
      end else if (dom_cnt_reg != '0) begin
         dom_cnt_reg <= dom_cnt_reg - CW'(1);
         dom_reg <= dom_cnt_reg != CW'(1);
      end else if (bus_wake_req) begin
         dom_cnt_reg <= CW'(DOM_CYC);
         dom_reg <= 1'b1;
      end
   end
   assign bus_wake_drive = dom_reg;

   // Host-timed dead time is the caller's job on these commands
   assign link.chip_enable = ce_reg;
   assign link.phase_high_cmd = user_high_cmd;
   assign link.phase_low_cmd = user_low_cmd;
   assign link.lin_tx_data = user_tx_data;
   assign rx_data = link.lin_rx_data;
   assign fault_seen = !link.current_fault_output;
endmodule

// ### tb/eswc_checker_sva.sv
module eswc_checker #(
   parameter int CE_QUAL_CYC = 40,
   parameter int WAKE_LOW_CYC = 10
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Link
   input wire logic chip_enable,
   input wire logic [2:0] phase_high_cmd,
   input wire logic [2:0] phase_low_cmd,
   input wire logic lin_tx_data,
   input wire logic lin_rx_data,
   input wire logic current_fault_output,
   // Device side
   input wire logic config_sleep_bit,
   input wire logic [3:0] config_reg_two,
   input wire logic fault_condition,
   input wire logic overcurrent,
   input wire logic lin_bus_i,
   input wire logic lin_bus_o,
   input wire logic lin_bus_oe,
   input wire logic lin_pullup_en,
   input wire eswc_pkg::eswc_mode_t power_mode,
   input wire logic fault_latched,
   input wire logic phase_a_high_gate,
   input wire logic phase_b_high_gate,
   input wire logic phase_c_high_gate,
   input wire logic phase_a_low_gate,
   input wire logic phase_b_low_gate,
   input wire logic phase_c_low_gate
);
   import eswc_pkg::*;
   logic [5:0] gates;
   logic [15:0] low_cnt_reg;
   assign gates = {phase_c_low_gate, phase_b_low_gate, phase_a_low_gate,
                   phase_c_high_gate, phase_b_high_gate, phase_a_high_gate};
   // Saturates so a long low never wraps into a false count
   always_ff @(posedge mclk) begin
      if (reset || chip_enable) begin
         low_cnt_reg <= 16'h0000;
      end else if (low_cnt_reg != 16'hFFFF) begin
         low_cnt_reg <= low_cnt_reg + 16'h0001;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // ==========================================
   // Properties
   sequence s_leave_active;
      $past(power_mode) == ESWC_ACTIVE && power_mode != ESWC_ACTIVE;
   endsequence
   sequence s_clean_rise;
      $rose(chip_enable) && !fault_condition;
   endsequence
   property p_gate_off;
      !chip_enable |-> gates == 6'h00;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("gate high with enable low");
   property p_gate_on;
      ($stable({phase_low_cmd, phase_high_cmd}) && chip_enable && power_mode == ESWC_ACTIVE
       && config_reg_two == 4'h0) [*3] |-> gates == {phase_low_cmd, phase_high_cmd};
   endproperty
   a_gate_on: assert property (p_gate_on) else $error("gates differ from commands");
   property p_qual_min;
      s_leave_active |-> low_cnt_reg >= CE_QUAL_CYC - 1;
   endproperty
   a_qual_min: assert property (p_qual_min) else $error("low power entered early");
   property p_qual_max;
      low_cnt_reg == CE_QUAL_CYC + 2 |-> power_mode != ESWC_ACTIVE;
   endproperty
   a_qual_max: assert property (p_qual_max) else $error("low power not entered");
   property p_sleep_sel;
      s_leave_active |-> power_mode == ($past(config_sleep_bit) ? ESWC_SLEEP : ESWC_STANDBY);
   endproperty
   a_sleep_sel: assert property (p_sleep_sel) else $error("wrong low power mode");
   property p_fault_clear;
      s_clean_rise |=> !fault_latched;
   endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");
   property p_wake;
      power_mode == ESWC_SLEEP && $rose(chip_enable) && low_cnt_reg >= WAKE_LOW_CYC
      |-> ##[1:2] power_mode == ESWC_ACTIVE;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on enable rise");
   property p_ilim;
      fault_latched || overcurrent |-> ##[0:1] !current_fault_output;
   endproperty
   a_ilim: assert property (p_ilim) else $error("fault output not low");
   property p_tx;
      (!lin_tx_data) [*2] |-> lin_bus_oe && !lin_bus_o;
   endproperty
   a_tx: assert property (p_tx) else $error("bus not dominant");
   property p_tx_rec;
      lin_tx_data [*2] |-> !lin_bus_oe;
   endproperty
   a_tx_rec: assert property (p_tx_rec) else $error("bus driven while recessive");
   property p_rx;
      (power_mode == ESWC_ACTIVE && !lin_bus_i) [*2] |-> !lin_rx_data;
   endproperty
   a_rx: assert property (p_rx) else $error("receive not following bus");
   property p_pullup;
      $stable(power_mode) && power_mode != ESWC_STANDBY |-> lin_pullup_en == (power_mode == ESWC_ACTIVE);
   endproperty
   a_pullup: assert property (p_pullup) else $error("bus pull-up wrong");
endmodule

// ### tb/enable_sleep_wake_control_tb.sv
module enable_sleep_wake_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import eswc_pkg::*;
   localparam int CE_Q = 40;
   localparam int WK = 10;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic user_enable = 1'b0, fault_clear_req = 1'b0, user_tx_data = 1'b1, bus_wake_req = 1'b0;
   logic [2:0] user_high_cmd = 3'h0, user_low_cmd = 3'h0;
   logic config_sleep_bit = 1'b0, fault_condition = 1'b0, overcurrent = 1'b0;
   logic [3:0] config_reg_two = 4'h0;
   logic busy, bus_wake_drive, rx_data, lin_bus_o, lin_bus_oe, lin_pullup_en, fault_latched;
   logic pullup_sel = 1'b1, wake_req = 1'b0;
   logic xlate_pullup_en, fault_seen;
   logic amp_en, reg12_en, buck_en, supervisor_en;
   logic ah, bh, ch, al, bl, cl;
   eswc_mode_t power_mode;
   int err_total = 0, n_tests = 0, cyc_cnt = 0;
   wire [5:0] gates = {cl, bl, al, ch, bh, ah};
   // Pull-up on the bus; host side pulls it low for a wake
   wire lin_bus = ~((lin_bus_oe & ~lin_bus_o) | bus_wake_drive);
   always #20 mclk = ~mclk;
   eswc_if eswc_if_inst ();
   eswc_device #(.CE_QUAL_CYC(CE_Q), .WAKE_LOW_CYC(WK), .LIN_DOM_CYC(6)) eswc_device_inst (
      .mclk(mclk), .reset(reset), .link(eswc_if_inst.device), .config_sleep_bit(config_sleep_bit),
      .pullup_select_bit(pullup_sel), .config_reg_two(config_reg_two), .fault_condition(fault_condition),
      .overcurrent(overcurrent), .high_volt_input_one(1'b1), .high_volt_input_two(1'b1),
      .lin_bus_i(lin_bus), .lin_bus_o(lin_bus_o), .lin_bus_oe(lin_bus_oe), .lin_pullup_en(lin_pullup_en),
      .xlate_pullup_en(xlate_pullup_en), .amp_en(amp_en), .reg12_en(reg12_en), .reg5_en(), .buck_en(buck_en),
      .supervisor_en(supervisor_en), .power_mode(power_mode), .fault_latched(fault_latched),
      .phase_a_high_gate(ah), .phase_b_high_gate(bh), .phase_c_high_gate(ch),
      .phase_a_low_gate(al), .phase_b_low_gate(bl), .phase_c_low_gate(cl));
   eswc_host #(.TOGGLE_CYC(8), .WAKE_LOW_CYC(WK), .DOM_CYC(12)) eswc_host_inst (
      .mclk(mclk), .reset(reset), .link(eswc_if_inst.host), .user_enable(user_enable),
      .fault_clear_req(fault_clear_req), .wake_req(wake_req), .user_high_cmd(user_high_cmd),
      .user_low_cmd(user_low_cmd), .user_tx_data(user_tx_data), .bus_wake_req(bus_wake_req),
      .busy(busy), .bus_wake_drive(bus_wake_drive), .rx_data(rx_data), .fault_seen(fault_seen));
   eswc_checker #(.CE_QUAL_CYC(CE_Q), .WAKE_LOW_CYC(WK)) eswc_checker_inst (
      .mclk(mclk), .reset(reset), .chip_enable(eswc_if_inst.chip_enable),
      .phase_high_cmd(eswc_if_inst.phase_high_cmd), .phase_low_cmd(eswc_if_inst.phase_low_cmd),
      .lin_tx_data(eswc_if_inst.lin_tx_data), .lin_rx_data(eswc_if_inst.lin_rx_data),
      .current_fault_output(eswc_if_inst.current_fault_output), .config_sleep_bit(config_sleep_bit),
      .config_reg_two(config_reg_two), .fault_condition(fault_condition), .overcurrent(overcurrent),
      .lin_bus_i(lin_bus), .lin_bus_o(lin_bus_o), .lin_bus_oe(lin_bus_oe), .lin_pullup_en(lin_pullup_en),
      .power_mode(power_mode), .fault_latched(fault_latched), .phase_a_high_gate(ah),
      .phase_b_high_gate(bh), .phase_c_high_gate(ch), .phase_a_low_gate(al),
      .phase_b_low_gate(bl), .phase_c_low_gate(cl));
   // ==========================================
   // Helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_mode(input eswc_mode_t got, input eswc_mode_t exp);
      chk(6'(got), 6'(exp));
   endtask
   task automatic wait_mode(input eswc_mode_t m);
      for (int i = 0; i < 100 && power_mode !== m; i++) cyc(1);
      chk_mode(power_mode, m);
   endtask
   task automatic clear_fault();
      @(posedge mclk) fault_clear_req <= 1'b1;
      @(posedge mclk) fault_clear_req <= 1'b0;
      cyc(1);
      for (int i = 0; i < 50 && busy !== 1'b0; i++) cyc(1);
      cyc(2);
   endtask
   task automatic final_report();
      $display("counts: %0d compares, %0d mismatches", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_drive();
      @(posedge mclk) user_enable <= 1'b1;
      cyc(4);
      chk({amp_en, reg12_en, buck_en, supervisor_en, eswc_if_inst.low_volt_output_one,
           eswc_if_inst.low_volt_output_two}, 6'h3F);
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk) {user_low_cmd, user_high_cmd} <= i ? 6'h2A : 6'h15;
         cyc(4);
         chk(gates, i ? 6'h2A : 6'h15);
      end
      @(posedge mclk) user_tx_data <= 1'b0;
      cyc(3);
      chk({4'h0, lin_bus, rx_data}, 6'h00);
      @(posedge mclk) user_tx_data <= 1'b1;
      cyc(3);
      chk({4'h0, lin_bus, rx_data}, 6'h03);
      @(posedge mclk) user_enable <= 1'b0;
      cyc(3);
      chk(gates, 6'h00);
      @(posedge mclk) user_enable <= 1'b1;
      {user_low_cmd, user_high_cmd} <= 6'h00;
      cyc(4);
      chk_mode(power_mode, ESWC_ACTIVE);
      $display("test drive done");
   endtask
   task automatic measure(input logic [3:0] dt, output int n);
      @(posedge mclk) config_reg_two <= dt;
      user_high_cmd <= 3'h0;
      cyc(4);
      @(posedge mclk) user_high_cmd <= 3'h1;
      n = 0;
      while (ah !== 1'b1 && n < 50) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic t_dead();
      int m0, m3;
      measure(4'h0, m0);
      measure(4'h3, m3);
      chk(6'(m3 - m0), 6'h03);
      @(posedge mclk) user_high_cmd <= 3'h0;
      config_reg_two <= 4'h0;
      $display("test dead time done");
   endtask
   task automatic t_fault();
      @(posedge mclk) fault_condition <= 1'b1;
      cyc(2);
      chk({3'h0, fault_seen, fault_latched, eswc_if_inst.current_fault_output}, 6'h06);
      clear_fault();
      chk({5'h0, fault_latched}, 6'h01);
      @(posedge mclk) fault_condition <= 1'b0;
      clear_fault();
      chk({4'h0, fault_latched, eswc_if_inst.current_fault_output}, 6'h01);
      chk_mode(power_mode, ESWC_ACTIVE);
      @(posedge mclk) overcurrent <= 1'b1;
      cyc(2);
      chk({4'h0, fault_seen, eswc_if_inst.current_fault_output}, 6'h02);
      @(posedge mclk) overcurrent <= 1'b0;
      $display("test fault done");
   endtask
   task automatic t_power(input logic s, input eswc_mode_t m);
      @(posedge mclk) config_sleep_bit <= s;
      user_enable <= 1'b0;
      pullup_sel <= s;
      cyc(CE_Q - 10);
      chk_mode(power_mode, ESWC_ACTIVE);
      wait_mode(m);
      // Pull-up setting loads one edge after Standby is reached
      cyc(2);
      if (s) chk({5'h0, lin_pullup_en}, 6'h00);
      else chk({amp_en, reg12_en, buck_en, supervisor_en, lin_pullup_en, 1'b0}, 6'h0C);
      // Sleep case wakes through the host's stretched low pulse
      @(posedge mclk) {user_enable, wake_req} <= {1'b1, s};
      @(posedge mclk) wake_req <= 1'b0;
      wait_mode(ESWC_ACTIVE);
      @(posedge mclk) pullup_sel <= ~s;
      cyc(2);
      chk({lin_pullup_en, gates[4:0]}, 6'h20);
      chk({5'h0, xlate_pullup_en}, {5'h0, s});
      $display("test power mode done");
   endtask
   task automatic t_lin();
      @(posedge mclk) config_sleep_bit <= 1'b1;
      user_enable <= 1'b0;
      wait_mode(ESWC_SLEEP);
      @(posedge mclk) bus_wake_req <= 1'b1;
      @(posedge mclk) bus_wake_req <= 1'b0;
      wait_mode(ESWC_ACTIVE);
      @(posedge mclk) user_enable <= 1'b1;
      cyc(4);
      chk({lin_pullup_en, gates[4:0]}, 6'h20);
      $display("test bus wake done");
   endtask
   // Cuts a hang short well past the expected run length
   always @(posedge mclk) begin
      cyc_cnt++;
      if (cyc_cnt == 3000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      t_drive();
      t_dead();
      t_fault();
      t_power(1'b0, ESWC_STANDBY);
      t_power(1'b1, ESWC_SLEEP);
      t_lin();
      final_report();
   end
endmodule
